// ### tmmc_pkg.sv
// Purpose: Constants for the tape manual motion control block.
// Assumes: 20 MHz clock; panel and mechanism levels are asynchronous.
// Notes: Timing constants derive from named times and the clock rate.
package tmmc_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned SEARCH_TIME_MS = 4000;
  localparam int unsigned SEARCH_CYCLES = SEARCH_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned FAKE_LP_TIME_US = 100;
  localparam int unsigned FAKE_LP_CYCLES = FAKE_LP_TIME_US * (CLK_HZ / 1000_000);
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic [31:0] CNT_ONE = 32'h0000_0001;
  localparam logic [31:0] CNT_ZERO = 32'h0000_0000;
endpackage : tmmc_pkg

// ### tmmc_sync_edge.sv
// Purpose: Two-stage synchronizer with rising-edge pulse.
// Assumes: Input asynchronous to clk_in.
// Notes: First stage feeds only the second stage.
`timescale 1ns/10ps
`default_nettype none
module tmmc_sync_edge
  import tmmc_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic async_in,
  output logic level_out,
  output logic rise_out
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else if (ce_in) begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign rise_out = sync_q & ~prev_q;
endmodule : tmmc_sync_edge
`default_nettype wire

// ### tmmc_timer.sv
// Purpose: Retriggerable down-counter one-shot.
// Assumes: start_in is a single-cycle pulse.
// Notes: expire_out pulses once when the count runs out.
`timescale 1ns/10ps
`default_nettype none
module tmmc_timer
  import tmmc_pkg::*;
#(
  parameter logic [31:0] CYCLES = 32'h0000_0010
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic start_in,
  input wire logic abort_in,
  output logic busy_out,
  output logic expire_out
);
  logic [31:0] cnt_q;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cnt_q <= CNT_ZERO;
      expire_out <= 1'b0;
    end else if (ce_in) begin
      expire_out <= 1'b0;
      if (abort_in) begin
        cnt_q <= CNT_ZERO;
      end else if (start_in) begin
        cnt_q <= CYCLES;
      end else if (cnt_q != CNT_ZERO) begin
        cnt_q <= cnt_q - CNT_ONE;
        expire_out <= (cnt_q == CNT_ONE);
      end
    end
  end

  assign busy_out = (cnt_q != CNT_ZERO);
endmodule : tmmc_timer
`default_nettype wire

// ### tmmc_top.sv
// Purpose: Manual motion control: remote qualify, load-point search, buttons.
// Assumes: All panel and mechanism inputs are asynchronous levels.
// Notes: Controller commands are gated by the remote qualification.
//
// The placing of the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none
module tmmc_top
  import tmmc_pkg::*;
#(
  parameter logic [31:0] SEARCH_CNT = 32'(SEARCH_CYCLES),
  parameter logic [31:0] FAKE_LP_CNT = 32'(FAKE_LP_CYCLES)
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic remote_mode_level_in,
  input wire logic unit_selected_in,
  input wire logic lp_search_request_in,
  input wire logic load_point_in,
  input wire logic rewind_in_progress_in,
  input wire logic reverse_button_level_in,
  input wire logic forward_button_level_in,
  input wire logic beginning_of_tape_level_in,
  input wire logic end_of_tape_level_in,
  input wire logic local_reset_level_in,
  input wire logic ctrl_set_forward_in,
  input wire logic ctrl_set_reverse_in,
  input wire logic ctrl_set_write_in,
  input wire logic ctrl_clear_function_in,
  output logic selected_and_remote_out,
  output logic forward_motion_out,
  output logic reverse_motion_out,
  output logic write_enable_out,
  output logic tape_removal_out,
  output logic search_active_out,
  output logic simulated_load_point_out,
  output logic master_clear_out,
  output logic buffer_clear_out
);
  logic remote_s;
  logic selected_s;
  logic lp_s;
  logic rewind_s;
  logic bot_s;
  logic eot_s;
  logic local_s;
  logic lp_search_rise;
  logic rev_rise;
  logic fwd_rise;
  logic local_rise;
  logic remote_fall_q;
  logic remote_prev_q;
  logic master_clear_d;
  logic set_reverse_pulse;
  logic set_forward_pulse;
  logic arm_q;
  logic search_busy;
  logic search_expire;
  logic fake_busy;
  logic fake_start;
  logic qual;

  // Synchronized levels and rising edges
  tmmc_sync_edge u_remote (.clk_in(clk_in), .srst_in(srst_in),
    .ce_in(ce_in), .async_in(remote_mode_level_in),
    .level_out(remote_s), .rise_out());
  tmmc_sync_edge u_sel (.clk_in(clk_in), .srst_in(srst_in),
    .ce_in(ce_in), .async_in(unit_selected_in),
    .level_out(selected_s), .rise_out());
  tmmc_sync_edge u_lps (.clk_in(clk_in), .srst_in(srst_in),
    .ce_in(ce_in), .async_in(lp_search_request_in),
    .level_out(), .rise_out(lp_search_rise));
  tmmc_sync_edge u_lp (.clk_in(clk_in), .srst_in(srst_in),
    .ce_in(ce_in), .async_in(load_point_in),
    .level_out(lp_s), .rise_out());
  tmmc_sync_edge u_rew (.clk_in(clk_in), .srst_in(srst_in),
    .ce_in(ce_in), .async_in(rewind_in_progress_in),
    .level_out(rewind_s), .rise_out());
  tmmc_sync_edge u_rev (.clk_in(clk_in), .srst_in(srst_in),
    .ce_in(ce_in), .async_in(reverse_button_level_in),
    .level_out(), .rise_out(rev_rise));
  tmmc_sync_edge u_fwd (.clk_in(clk_in), .srst_in(srst_in),
    .ce_in(ce_in), .async_in(forward_button_level_in),
    .level_out(), .rise_out(fwd_rise));
  tmmc_sync_edge u_bot (.clk_in(clk_in), .srst_in(srst_in),
    .ce_in(ce_in), .async_in(beginning_of_tape_level_in),
    .level_out(bot_s), .rise_out());
  tmmc_sync_edge u_eot (.clk_in(clk_in), .srst_in(srst_in),
    .ce_in(ce_in), .async_in(end_of_tape_level_in),
    .level_out(eot_s), .rise_out());
  tmmc_sync_edge u_loc (.clk_in(clk_in), .srst_in(srst_in),
    .ce_in(ce_in), .async_in(local_reset_level_in),
    .level_out(local_s), .rise_out(local_rise));

  assign qual = remote_s & selected_s;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      selected_and_remote_out <= 1'b0;
    end else if (ce_in) begin
      selected_and_remote_out <= qual;
    end
  end

  // Master clear on local reset rise and on leaving remote mode
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      remote_prev_q <= 1'b0;
      remote_fall_q <= 1'b0;
    end else if (ce_in) begin
      remote_prev_q <= remote_s;
      remote_fall_q <= remote_prev_q & ~remote_s;
    end
  end

  assign master_clear_d = local_rise | remote_fall_q |
    (qual & ctrl_clear_function_in);

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      master_clear_out <= 1'b0;
      buffer_clear_out <= 1'b0;
    end else if (ce_in) begin
      master_clear_out <= master_clear_d;
      buffer_clear_out <= master_clear_d;
    end
  end

  // Set pulses: local buttons, or controller commands when qualified
  assign set_reverse_pulse = (rev_rise & ~remote_s) |
    (qual & ctrl_set_reverse_in);
  assign set_forward_pulse = (fwd_rise & ~remote_s) |
    (qual & ctrl_set_forward_in);

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      reverse_motion_out <= 1'b0;
    end else if (ce_in) begin
      if (rewind_s || master_clear_d || bot_s) begin
        reverse_motion_out <= 1'b0;
      end else if (set_reverse_pulse && !forward_motion_out) begin
        reverse_motion_out <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      forward_motion_out <= 1'b0;
    end else if (ce_in) begin
      if (rewind_s || master_clear_d || (eot_s && !remote_s)) begin
        forward_motion_out <= 1'b0;
      end else if (set_forward_pulse && !reverse_motion_out) begin
        forward_motion_out <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      write_enable_out <= 1'b0;
    end else if (ce_in) begin
      if (rewind_s || local_s || master_clear_d || !qual) begin
        write_enable_out <= 1'b0;
      end else if (ctrl_set_write_in) begin
        write_enable_out <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      tape_removal_out <= 1'b0;
    end else if (ce_in) begin
      if (master_clear_d) begin
        tape_removal_out <= 1'b0;
      end
    end
  end

  // Load-point search timer and arming flip-flop
  tmmc_timer #(.CYCLES(SEARCH_CNT)) u_search (.clk_in(clk_in),
    .srst_in(srst_in), .ce_in(ce_in), .start_in(lp_search_rise),
    .abort_in(1'b0), .busy_out(search_busy),
    .expire_out(search_expire));

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      arm_q <= 1'b0;
    end else if (ce_in) begin
      if (lp_search_rise) begin
        arm_q <= 1'b1;
      end else if ((search_busy && lp_s) || search_expire ||
                   master_clear_d) begin
        arm_q <= 1'b0;
      end
    end
  end

  assign fake_start = search_expire & arm_q & ~lp_s;

  tmmc_timer #(.CYCLES(FAKE_LP_CNT)) u_fake (.clk_in(clk_in),
    .srst_in(srst_in), .ce_in(ce_in), .start_in(fake_start),
    .abort_in(master_clear_d), .busy_out(fake_busy),
    .expire_out());

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      simulated_load_point_out <= 1'b0;
      search_active_out <= 1'b0;
    end else if (ce_in) begin
      simulated_load_point_out <= fake_busy | fake_start;
      search_active_out <= search_busy | lp_search_rise;
    end
  end
endmodule : tmmc_top
`default_nettype wire

// ### tmmc_top_sva.sv
// Purpose: Port checks for tmmc_top.
// Assumes: ce_in held high.
// Notes: Level clears land three edges after the pin changes.
`timescale 1ns/10ps
`default_nettype none
module tmmc_top_chk #(
  parameter logic [31:0] FAKE_LP_CNT = 32'h0000_0004
) (
  input wire logic clk_in, srst_in, remote_mode_level_in, unit_selected_in,
  input wire logic rewind_in_progress_in, beginning_of_tape_level_in,
  input wire logic end_of_tape_level_in, local_reset_level_in,
  input wire logic selected_and_remote_out, forward_motion_out,
  input wire logic reverse_motion_out, write_enable_out,
  input wire logic simulated_load_point_out, master_clear_out,
  input wire logic buffer_clear_out
);
  logic [31:0] fc_q;
  logic rs_w, eot_w, run_w;
  assign rs_w = remote_mode_level_in && unit_selected_in;
  assign eot_w = end_of_tape_level_in && !remote_mode_level_in;
  assign run_w = forward_motion_out || reverse_motion_out || write_enable_out;
  // Length of the current simulated load-point pulse
  always_ff @(posedge clk_in) begin
    if (srst_in || !simulated_load_point_out) fc_q <= 32'h0000_0000;
    else fc_q <= fc_q + 32'h0000_0001;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  chk_sel_on: assert property (rs_w[*4] |-> selected_and_remote_out)
    else $error("qualify missing");
  chk_sel_off: assert property ((!rs_w)[*4] |->
    !selected_and_remote_out && !write_enable_out)
    else $error("qualify stuck");
  chk_rew_hold: assert property (
    rewind_in_progress_in[*4] |-> !run_w) else $error("rewind motion");
  chk_bot_rev: assert property (
    beginning_of_tape_level_in[*4] |-> !reverse_motion_out) else $error("bot");
  chk_eot_fwd: assert property (
    eot_w[*4] |-> !forward_motion_out) else $error("eot");
  chk_local_clr: assert property (
    local_reset_level_in[*4] |-> !run_w) else $error("local motion");
  chk_mc_pulse: assert property (
    $rose(local_reset_level_in) |-> ##[2:4] master_clear_out)
    else $error("no master clear");
  chk_mc_buf: assert property (
    master_clear_out |-> buffer_clear_out ##1 !master_clear_out)
    else $error("clear pulse");
  chk_fake_len: assert property (
    $fell(simulated_load_point_out) |-> fc_q == FAKE_LP_CNT + 32'h0000_0001)
    else $error("fake length");
  cover property ($rose(simulated_load_point_out));
  cover property ($rose(forward_motion_out));
  cover property (master_clear_out);
endmodule : tmmc_top_chk
bind tmmc_top tmmc_top_chk #(.FAKE_LP_CNT(FAKE_LP_CNT)) u_chk (.*);
`default_nettype wire

// ### tmmc_mech_model.sv
// Purpose: Tape mechanism stand-in for tmmc_top.
// Assumes: One tape step per clock.
// Notes: Markers sit at fixed step positions.
`timescale 1ns/10ps
`default_nettype none
module tmmc_mech_model #(
  parameter int LP_POS = 20,
  parameter int EOT_POS = 50
) (
  input wire logic clk_in, srst_in, fwd_in, rev_in,
  input wire logic search_in, fake_lp_in, rewind_go_in,
  output logic load_point_out, bot_out, eot_out, rewind_out
);
  int pos_q, rew_q;
  logic back_q, go_f, go_r;
  assign load_point_out = pos_q == LP_POS;
  assign bot_out = pos_q == 0;
  assign eot_out = pos_q == EOT_POS;
  assign rewind_out = rew_q != 0;
  assign go_f = fwd_in || (search_in && !load_point_out);
  assign go_r = rev_in || (back_q && !load_point_out);
  always_ff @(posedge clk_in) begin
    if (srst_in || load_point_out) back_q <= 1'b0;
    else if (fake_lp_in) back_q <= 1'b1;
  end
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pos_q <= 0;
      rew_q <= 0;
    end else if (rew_q != 0) begin
      rew_q <= rew_q - 1;
      pos_q <= 0;
    end else if (rewind_go_in) begin
      rew_q <= 20;
    end else if (go_f && pos_q < EOT_POS) begin
      pos_q <= pos_q + 1;
    end else if (go_r && pos_q > 0) begin
      pos_q <= pos_q - 1;
    end
  end
endmodule : tmmc_mech_model
`default_nettype wire

// ### tmmc_test.sv
// Purpose: Self-checking bench for tmmc_top.
// Assumes: Short search and one-shot counts.
// Notes: Results are read at the falling edge.
`timescale 1ns/10ps
`default_nettype none
module tmmc_test;
  logic clk = 1'b0, rst = 1'b1, rem = 1'b0, sel = 1'b0, rg = 1'b0;
  logic [3:0] btn = 4'h0, ctl = 4'h0;
  logic lp, bot, eot, rw, sar, fwd, rev, we, sa, sim, mc, tr;
  int failures = 0, n_tests = 0, n_fake = 0, n_mc = 0, k;
  always #25 clk = ~clk;
  always @(posedge sim) n_fake++;
  always @(posedge mc) n_mc++;
  tmmc_top #(.SEARCH_CNT(32'h0000_0032), .FAKE_LP_CNT(32'h0000_0004)) dut (
    .clk_in(clk), .srst_in(rst), .ce_in(1'b1), .remote_mode_level_in(rem),
    .unit_selected_in(sel), .lp_search_request_in(btn[3]), .load_point_in(lp),
    .rewind_in_progress_in(rw), .reverse_button_level_in(btn[1]),
    .forward_button_level_in(btn[0]), .beginning_of_tape_level_in(bot),
    .end_of_tape_level_in(eot), .local_reset_level_in(btn[2]),
    .ctrl_set_forward_in(ctl[0]), .ctrl_set_reverse_in(ctl[1]),
    .ctrl_set_write_in(ctl[2]), .ctrl_clear_function_in(ctl[3]),
    .selected_and_remote_out(sar), .forward_motion_out(fwd),
    .reverse_motion_out(rev), .write_enable_out(we), .tape_removal_out(tr),
    .search_active_out(sa), .simulated_load_point_out(sim),
    .master_clear_out(mc), .buffer_clear_out());
  tmmc_mech_model mech (.clk_in(clk), .srst_in(rst), .fwd_in(fwd),
    .rev_in(rev), .search_in(btn[3]), .fake_lp_in(sim), .rewind_go_in(rg),
    .load_point_out(lp), .bot_out(bot), .eot_out(eot), .rewind_out(rw));
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task press(input int b, input int n);
    @(posedge clk) btn[b] <= 1'b1;
    cyc(n);
    @(posedge clk) btn[b] <= 1'b0;
    cyc(8);
  endtask : press
  task ctrl(input int b);
    @(posedge clk) ctl[b] <= 1'b1;
    @(posedge clk) ctl[b] <= 1'b0;
    cyc(3);
  endtask : ctrl
  task cmp(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task fin(input string s);
    $display("test %s done", s);
  endtask : fin
  task complete_run;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  initial begin
    cyc(3000);
    failures++;
    complete_run;
  end
  initial begin
    cyc(4);
    @(posedge clk) rst <= 1'b0;
    @(posedge clk) {rem, sel} <= 2'h3;
    cyc(6);
    cmp(sar, 1'b1);
    ctrl(2);
    cmp(we, 1'b1);
    press(0, 4);
    cmp(fwd, 1'b0);
    @(posedge clk) sel <= 1'b0;
    cyc(6);
    ctrl(0);
    cmp(sar | we | fwd, 1'b0);
    @(posedge clk) sel <= 1'b1;
    cyc(6);
    ctrl(0);
    ctrl(1);
    cmp(fwd & ~rev, 1'b1);
    ctrl(3);
    cmp(fwd, 1'b0);
    @(posedge clk) rem <= 1'b0;
    cyc(6);
    fin("remote");
    @(posedge clk) btn[3] <= 1'b1;
    cyc(6);
    cmp(sa, 1'b1);
    cyc(70);
    @(posedge clk) btn[3] <= 1'b0;
    cyc(6);
    cmp(lp && n_fake == 0, 1'b1);
    fin("search_found");
    press(0, 4);
    cmp(fwd, 1'b1);
    press(1, 4);
    cmp(rev, 1'b0);
    cyc(40);
    cmp(eot & ~fwd, 1'b1);
    fin("forward");
    @(posedge clk) btn[3] <= 1'b1;
    cyc(70);
    @(posedge clk) btn[3] <= 1'b0;
    cyc(45);
    cmp(lp && n_fake == 1, 1'b1);
    fin("fake_lp");
    press(1, 4);
    cmp(rev, 1'b1);
    press(0, 4);
    cmp(fwd, 1'b0);
    cyc(10);
    cmp(bot & ~rev, 1'b1);
    fin("reverse");
    press(0, 4);
    cmp(fwd, 1'b1);
    k = n_mc;
    press(2, 6);
    cmp(~fwd && n_mc == k + 1, 1'b1);
    cmp(tr, 1'b0);
    fin("local");
    @(posedge clk) {rem, sel} <= 2'h3;
    cyc(6);
    ctrl(2);
    ctrl(0);
    cmp(fwd & we, 1'b1);
    @(posedge clk) rg <= 1'b1;
    @(posedge clk) rg <= 1'b0;
    cyc(6);
    cmp(fwd | we, 1'b0);
    fin("rewind");
    complete_run;
  end
endmodule : tmmc_test
`default_nettype wire
